// ===== uwsl_pkg.sv
`default_nettype none
package uwsl_pkg;
  // ****************************************************************
  // Instruction fields
  // ****************************************************************
  localparam logic [5:0] OPC_LEFT = 6'h2A;
  localparam logic [5:0] OPC_RIGHT = 6'h2E;
  localparam int OPC_LSB = 26;
  localparam int BASE_LSB = 21;
  localparam int SRC_LSB = 16;
  localparam int OFS_W = 16;
  localparam int ADDR_W = 64;
  localparam int PADDR_W = 36;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [63:0] DATA_RST = 64'h0000000000000000;
  localparam logic [7:0] LANES_RST = 8'h00;
  localparam logic [2:0] SIZE_RST = 3'h0;

  typedef enum logic [1:0] {
    UWSL_OP_NONE = 2'b00,
    UWSL_OP_LEFT = 2'b01,
    UWSL_OP_RIGHT = 2'b10
  } uwsl_op_t;

  typedef struct packed {
    logic [31:0] instr;
    logic [63:0] base_val;
    logic [63:0] src_val;
    logic [PADDR_W-1:0] paddr;
    logic cpu_big_endian_flag;
    logic memory_big_endian_flag;
    logic reverse_byte_order_flag;
  } uwsl_req_t;

  typedef struct packed {
    logic valid;
    logic [PADDR_W-1:0] paddr;
    logic [2:0] size;
    logic [7:0] lanes;
    logic [63:0] data;
  } uwsl_wr_t;

  typedef struct packed {
    logic tlb_refill;
    logic tlb_invalid;
    logic tlb_modified;
    logic bus_error;
    logic address_error;
  } uwsl_exc_t;
endpackage
`default_nettype wire

// ===== uwsl_lane_steer.sv
`timescale 1ns/100ps
`default_nettype none
module uwsl_lane_steer (
  input wire uwsl_pkg::uwsl_op_t op,
  input wire logic [1:0] byte_idx,
  input wire logic half_sel,
  input wire logic [31:0] src_word,
  output logic [2:0] size,
  output logic [7:0] lanes,
  output logic [63:0] data
);
  import uwsl_pkg::*;

  logic [31:0] word;
  logic [3:0] mask;

  always_comb begin
    word = 32'h00000000;
    mask = 4'h0;
    size = 3'h0;
    case (op)
      UWSL_OP_LEFT: begin
        // High source bytes right-justified, zeros above.
        word = src_word >> (5'd24 - {byte_idx, 3'b000});
        mask = 4'hF >> (3'd3 - {1'b0, byte_idx});
        size = {1'b0, byte_idx};
      end
      UWSL_OP_RIGHT: begin
        // Low source bytes shifted up, zeros below.
        word = src_word << {byte_idx, 3'b000};
        mask = 4'hF << byte_idx;
        size = 3'd4 - {1'b0, byte_idx};
      end
      default: begin
        word = 32'h00000000;
      end
    endcase
  end

  // Unselected lanes carry no enable, so memory keeps them.
  assign data = half_sel ? {word, 32'h00000000} : {32'h00000000, word};
  assign lanes = half_sel ? {mask, 4'h0} : {4'h0, mask};
endmodule
`default_nettype wire

// ===== uwsl_store_unit.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// - Opcode 101010 decodes left store; base, source, offset fields fixed.
// - Opcode 101110 decodes right store with same field positions.
// - Effective address is sign-extended offset plus base register.
// - Left store writes high source bytes ending at address.
// - Right store writes low source bytes starting at address.
// - Only low 32 bits of source register are stored.
// - Lane choice uses address bits 2..0 and CPU byte order.
// - Left store lane table for both byte orders.
// - Right store lane table for both byte orders.
// - Little-endian memory forces physical address bits 1..0 to zero.
// - Left store size equals byte index, data right-justified.
// - Translation, bus and address error exceptions can be raised.
// - Misalignment alone never raises an alignment exception.
// - Unselected byte lanes stay unchanged.
module uwsl_store_unit (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire uwsl_pkg::uwsl_req_t req,
  input wire uwsl_pkg::uwsl_exc_t xlat_exc,
  output uwsl_pkg::uwsl_wr_t wr,
  output uwsl_pkg::uwsl_exc_t exc,
  output logic [63:0] effective_addr
);
  import uwsl_pkg::*;

  // ****************************************************************
  // Decode
  // ****************************************************************
  uwsl_op_t op;
  logic [4:0] base_field;
  logic [4:0] source_reg_field;
  logic [15:0] ofs;
  logic [63:0] virtual_addr;
  logic [1:0] byte_idx;
  logic half_sel;
  logic [PADDR_W-1:0] paddr_adj;
  logic [2:0] st_size;
  logic [7:0] st_lanes;
  logic [63:0] st_data;
  logic fire;

  always_comb begin
    case (req.instr[31:OPC_LSB])
      OPC_LEFT: op = UWSL_OP_LEFT;
      OPC_RIGHT: op = UWSL_OP_RIGHT;
      default: op = UWSL_OP_NONE;
    endcase
  end

  assign base_field = req.instr[BASE_LSB+4:BASE_LSB];
  assign source_reg_field = req.instr[SRC_LSB+4:SRC_LSB];
  assign ofs = req.instr[OFS_W-1:0];
  // Register file is read outside; base_field and source_reg_field name the operands.
  assign virtual_addr = req.base_val + {{(ADDR_W-OFS_W){ofs[15]}}, ofs};
  assign byte_idx = virtual_addr[1:0] ^ {2{req.cpu_big_endian_flag}};
  assign half_sel = virtual_addr[2] ^ req.cpu_big_endian_flag;
  assign fire = req_valid && (op != UWSL_OP_NONE);

  // ****************************************************************
  // Physical address adjustment
  // ****************************************************************
  always_comb begin
    paddr_adj = req.paddr ^ {{(PADDR_W-3){1'b0}}, {3{req.reverse_byte_order_flag}}};
    if (!req.memory_big_endian_flag) begin
      paddr_adj[1:0] = 2'b00;
    end
  end

  uwsl_lane_steer u_steer (
    .op(op),
    .byte_idx(byte_idx),
    .half_sel(half_sel),
    .src_word(req.src_val[31:0]),
    .size(st_size),
    .lanes(st_lanes),
    .data(st_data)
  );

  // ****************************************************************
  // Store port
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr <= '{valid: 1'b0, paddr: '0, size: SIZE_RST, lanes: LANES_RST, data: DATA_RST};
    end else begin
      // A store goes out only if no exception blocks it; no alignment check.
      wr.valid <= fire && (xlat_exc == '0);
      wr.paddr <= paddr_adj;
      wr.size <= st_size;
      wr.lanes <= (fire && (xlat_exc == '0)) ? st_lanes : LANES_RST;
      wr.data <= st_data;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      exc <= '0;
      effective_addr <= DATA_RST;
    end else begin
      // Translation, bus and address error faults pass; misalignment is legal here.
      exc <= fire ? xlat_exc : '0;
      effective_addr <= virtual_addr;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_left_size;
    @(posedge mclk) disable iff (!nrst)
      (fire && op == UWSL_OP_LEFT && xlat_exc == '0) |=> (wr.size == $past(byte_idx, 1));
  endproperty
  a_left_size: assert property (p_left_size) else $error("left size wrong");

  property p_right_size;
    @(posedge mclk) disable iff (!nrst)
      (fire && op == UWSL_OP_RIGHT) |=> (wr.size == 3'd4 - {1'b0, $past(byte_idx, 1)});
  endproperty
  a_right_size: assert property (p_right_size) else $error("right size wrong");

  property p_le_mem;
    @(posedge mclk) disable iff (!nrst)
      (fire && !req.memory_big_endian_flag) |=> (wr.paddr[1:0] == 2'b00);
  endproperty
  a_le_mem: assert property (p_le_mem) else $error("paddr low bits not cleared");

  property p_no_misalign;
    @(posedge mclk) disable iff (!nrst)
      (fire && xlat_exc == '0) |=> (wr.valid && exc == '0);
  endproperty
  a_no_misalign: assert property (p_no_misalign) else $error("store blocked");

  property p_exc_pass;
    @(posedge mclk) disable iff (!nrst)
      (fire && xlat_exc != '0) |=> (!wr.valid && exc == $past(xlat_exc, 1));
  endproperty
  a_exc_pass: assert property (p_exc_pass) else $error("exception lost");

  property p_half;
    @(posedge mclk) disable iff (!nrst)
      (fire && xlat_exc == '0) |=> ($past(half_sel, 1) ? wr.lanes[3:0] == 4'h0
                                                        : wr.lanes[7:4] == 4'h0);
  endproperty
  a_half: assert property (p_half) else $error("wrong half");

  property p_ea;
    @(posedge mclk) disable iff (!nrst)
      1'b1 |=> (effective_addr == $past(req.base_val, 1)
                + {{48{$past(req.instr[15], 1)}}, $past(req.instr[15:0], 1)});
  endproperty
  a_ea: assert property (p_ea) else $error("effective address wrong");

  property p_left_full;
    @(posedge mclk) disable iff (!nrst)
      (fire && op == UWSL_OP_LEFT && xlat_exc == '0 && byte_idx == 2'd3)
        |=> (wr.lanes == 8'h0F || wr.lanes == 8'hF0);
  endproperty
  a_left_full: assert property (p_left_full) else $error("left full lanes");

  property p_right_one;
    @(posedge mclk) disable iff (!nrst)
      (fire && op == UWSL_OP_RIGHT && xlat_exc == '0 && byte_idx == 2'd3)
        |=> (wr.lanes == 8'h08 || wr.lanes == 8'h80);
  endproperty
  a_right_one: assert property (p_right_one) else $error("right one lane");

  property p_idle;
    @(posedge mclk) disable iff (!nrst)
      !fire |=> (!wr.valid && wr.lanes == 8'h00);
  endproperty
  a_idle: assert property (p_idle) else $error("spurious store");

  property p_low_word;
    @(posedge mclk) disable iff (!nrst)
      (fire && op == UWSL_OP_RIGHT && xlat_exc == '0 && byte_idx == 2'd0 && !half_sel)
        |=> (wr.data[31:0] == $past(req.src_val[31:0], 1));
  endproperty
  a_low_word: assert property (p_low_word) else $error("source word wrong");

  // ****************************************************************
  // Check helpers
  // ****************************************************************
  // Byte enables spread to bit masks, so data outside the lanes can be seen.
  logic [63:0] lane_bits;

  for (genvar g = 0; g < 8; g++) begin : g_lane_bits
    assign lane_bits[8*g +: 8] = {8{wr.lanes[g]}};
  end

  sequence s_take_left;
    fire && op == UWSL_OP_LEFT && xlat_exc == '0;
  endsequence

  sequence s_take_right;
    fire && op == UWSL_OP_RIGHT && xlat_exc == '0;
  endsequence

  sequence s_take_blocked;
    fire && xlat_exc != '0;
  endsequence

  sequence s_store_out;
    wr.valid && exc == '0;
  endsequence

  property p_dec_left;
    @(posedge mclk) disable iff (!nrst)
      (req_valid && req.instr[31:26] == OPC_LEFT && xlat_exc == '0) |=> s_store_out;
  endproperty
  a_dec_left: assert property (p_dec_left) else $error("left store lost");

  property p_dec_right;
    @(posedge mclk) disable iff (!nrst)
      (req_valid && req.instr[31:26] == OPC_RIGHT && xlat_exc == '0) |=> s_store_out;
  endproperty
  a_dec_right: assert property (p_dec_right) else $error("right store lost");

  property p_dec_other;
    @(posedge mclk) disable iff (!nrst)
      (req.instr[31:26] != OPC_LEFT && req.instr[31:26] != OPC_RIGHT)
        |=> (!wr.valid && exc == '0);
  endproperty
  a_dec_other: assert property (p_dec_other) else $error("stray store");

  property p_fields;
    @(posedge mclk) disable iff (!nrst)
      fire |-> (base_field == req.instr[25:21] && source_reg_field == req.instr[20:16]
                && ofs == req.instr[15:0]);
  endproperty
  a_fields: assert property (p_fields) else $error("field decode wrong");

  property p_src_low_left;
    @(posedge mclk) disable iff (!nrst)
      (s_take_left ##0 (byte_idx == 2'h3 && !half_sel))
        |=> (wr.data == {32'h00000000, $past(req.src_val[31:0], 1)});
  endproperty
  a_src_low_left: assert property (p_src_low_left) else $error("upper half used");

  property p_src_up_right;
    @(posedge mclk) disable iff (!nrst)
      (s_take_right ##0 (byte_idx == 2'h0 && half_sel))
        |=> (wr.data == {$past(req.src_val[31:0], 1), 32'h00000000});
  endproperty
  a_src_up_right: assert property (p_src_up_right) else $error("upper word wrong");

  property p_left_one;
    @(posedge mclk) disable iff (!nrst)
      (s_take_left ##0 (byte_idx == 2'h0)) |=> (wr.lanes == 8'h01 || wr.lanes == 8'h10);
  endproperty
  a_left_one: assert property (p_left_one) else $error("left one lane");

  property p_right_full;
    @(posedge mclk) disable iff (!nrst)
      (s_take_right ##0 (byte_idx == 2'h0)) |=> (wr.lanes == 8'h0F || wr.lanes == 8'hF0);
  endproperty
  a_right_full: assert property (p_right_full) else $error("right full lanes");

  property p_zero_fill;
    @(posedge mclk) disable iff (!nrst)
      s_store_out |-> ((wr.data & ~lane_bits) == 64'h0000000000000000);
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("stray data");

  property p_left_count;
    @(posedge mclk) disable iff (!nrst)
      s_take_left |=> ($countones(wr.lanes) == wr.size + 1);
  endproperty
  a_left_count: assert property (p_left_count) else $error("left lane count");

  property p_right_count;
    @(posedge mclk) disable iff (!nrst)
      s_take_right |=> ($countones(wr.lanes) == wr.size);
  endproperty
  a_right_count: assert property (p_right_count) else $error("right lane count");

  property p_left_anchor;
    @(posedge mclk) disable iff (!nrst)
      s_take_left |=> (wr.lanes[0] || wr.lanes[4]);
  endproperty
  a_left_anchor: assert property (p_left_anchor) else $error("left not justified");

  property p_right_anchor;
    @(posedge mclk) disable iff (!nrst)
      s_take_right |=> (wr.lanes[3] || wr.lanes[7]);
  endproperty
  a_right_anchor: assert property (p_right_anchor) else $error("right not on top");

  property p_be_offset0;
    @(posedge mclk) disable iff (!nrst)
      (s_take_left ##0 (req.cpu_big_endian_flag && virtual_addr[1:0] == 2'h0))
        |=> (wr.size == 3'h3);
  endproperty
  a_be_offset0: assert property (p_be_offset0) else $error("byte order ignored");

  property p_be_mem_keep;
    @(posedge mclk) disable iff (!nrst)
      (fire && req.memory_big_endian_flag) |=> (wr.paddr[2:0] ==
        ($past(req.paddr[2:0], 1) ^ {3{$past(req.reverse_byte_order_flag, 1)}}));
  endproperty
  a_be_mem_keep: assert property (p_be_mem_keep) else $error("byte address wrong");

  property p_paddr_high;
    @(posedge mclk) disable iff (!nrst)
      fire |=> (wr.paddr[PADDR_W-1:3] == $past(req.paddr[PADDR_W-1:3], 1));
  endproperty
  a_paddr_high: assert property (p_paddr_high) else $error("upper address");

  property p_exc_idle;
    @(posedge mclk) disable iff (!nrst)
      !fire |=> (exc == '0);
  endproperty
  a_exc_idle: assert property (p_exc_idle) else $error("spurious exception");

  property p_blocked_lanes;
    @(posedge mclk) disable iff (!nrst)
      s_take_blocked |=> (!wr.valid && wr.lanes == 8'h00);
  endproperty
  a_blocked_lanes: assert property (p_blocked_lanes) else $error("blocked store");
endmodule
`default_nettype wire

// ===== uwsl_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module uwsl_mem_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire uwsl_pkg::uwsl_wr_t wr,
  output logic [255:0] image
);
  import uwsl_pkg::*;
  // ****************************************************************
  // Store port backing memory
  // ****************************************************************
  logic [63:0] mem_q [0:3];
  // A nonzero fill makes any stray lane write visible.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        mem_q[i] <= 64'hA5A5A5A5A5A5A5A5;
      end
    end else if (wr.valid) begin
      for (int b = 0; b < 8; b++) begin
        if (wr.lanes[b]) begin
          mem_q[wr.paddr[4:3]][8*b +: 8] <= wr.data[8*b +: 8];
        end
      end
    end
  end
  assign image = {mem_q[3], mem_q[2], mem_q[1], mem_q[0]};
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import uwsl_pkg::*;
  // ****************************************************************
  // Bench
  // ****************************************************************
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  uwsl_req_t req = '0;
  uwsl_exc_t xlat_exc = '0;
  uwsl_wr_t wr;
  uwsl_exc_t exc;
  logic [63:0] effective_addr;
  logic [255:0] image;
  logic [63:0] exp_mem [0:3];
  int n_errors = 0;
  int n_checks = 0;
  always #20 mclk = ~mclk;
  uwsl_store_unit dut_u (.mclk(mclk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .xlat_exc(xlat_exc), .wr(wr), .exc(exc), .effective_addr(effective_addr));
  uwsl_mem_model mem_u (.mclk(mclk), .nrst(nrst), .wr(wr), .image(image));
  task automatic complete_run;
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic uwsl_req_t mk(input logic [5:0] opc, input logic [63:0] base,
    input logic [15:0] ofs, input logic [63:0] src, input logic cbe);
    uwsl_req_t r;
    logic [63:0] ea;
    ea = base + {{48{ofs[15]}}, ofs};
    r.instr = {opc, 5'($urandom), 5'($urandom), ofs};
    r.base_val = base;
    r.src_val = src;
    r.paddr = {31'($urandom), ea[4:0]};
    r.cpu_big_endian_flag = cbe;
    r.memory_big_endian_flag = 1'($urandom);
    r.reverse_byte_order_flag = 1'($urandom);
    return r;
  endfunction
  function automatic uwsl_wr_t expect_wr(input uwsl_req_t r, input bit left,
    input logic [63:0] ea);
    uwsl_wr_t w;
    logic [1:0] idx;
    logic [31:0] word;
    logic [3:0] mask;
    logic half;
    idx = ea[1:0] ^ {2{r.cpu_big_endian_flag}};
    half = ea[2] ^ r.cpu_big_endian_flag;
    w.size = left ? {1'b0, idx} : 3'h4 - {1'b0, idx};
    word = left ? r.src_val[31:0] >> (24 - 8 * idx) : r.src_val[31:0] << (8 * idx);
    mask = left ? 4'hF >> (3 - idx) : 4'hF << idx;
    w.data = half ? {word, 32'h0} : {32'h0, word};
    w.lanes = half ? {mask, 4'h0} : {4'h0, mask};
    w.paddr = r.paddr ^ {33'h0, {3{r.reverse_byte_order_flag}}};
    if (!r.memory_big_endian_flag) w.paddr[1:0] = 2'h0;
    w.valid = 1'b1;
    return w;
  endfunction
  // Entered at a falling edge; checks the answer one cycle later.
  task automatic issue(input uwsl_req_t r, input uwsl_exc_t xe, input logic vld);
    uwsl_wr_t w;
    logic [63:0] ea;
    bit dec;
    dec = vld && (r.instr[31:26] == OPC_LEFT || r.instr[31:26] == OPC_RIGHT);
    ea = r.base_val + {{48{r.instr[15]}}, r.instr[15:0]};
    w = expect_wr(r, r.instr[31:26] == OPC_LEFT, ea);
    req = r;
    req_valid = vld;
    xlat_exc = xe;
    @(posedge mclk);
    @(negedge mclk);
    for (int i = 0; i < 4; i++) chk("memory", exp_mem[i], image[64*i +: 64]);
    chk("effective_addr", ea, effective_addr);
    chk("exc", dec ? 64'(xe) : 64'h0, 64'(exc));
    if (!dec || xe != '0) begin
      chk("valid", 64'h0, 64'(wr.valid));
      chk("lanes", 64'h0, 64'(wr.lanes));
    end else begin
      chk("valid", 64'h1, 64'(wr.valid));
      chk("lanes", 64'(w.lanes), 64'(wr.lanes));
      chk("size", 64'(w.size), 64'(wr.size));
      chk("data", w.data, wr.data);
      chk("paddr", 64'(w.paddr), 64'(wr.paddr));
      for (int b = 0; b < 8; b++) begin
        if (w.lanes[b]) exp_mem[w.paddr[4:3]][8*b +: 8] = w.data[8*b +: 8];
      end
    end
  endtask
  initial begin
    logic [5:0] opc;
    void'($urandom(32'h75150148));
    for (int i = 0; i < 4; i++) exp_mem[i] = 64'hA5A5A5A5A5A5A5A5;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    nrst = 1'b1;
    for (int k = 0; k < 16; k++) begin
      opc = k[3] ? OPC_RIGHT : OPC_LEFT;
      issue(mk(opc, 64'h100, 16'(k % 4), 64'hFFFFFFFF11223344, k[2]), '0, 1'b1);
    end
    issue(mk(OPC_LEFT, 64'h218, 16'h2, 64'h55667788, 1'b1), '0, 1'b1);
    chk("sweep word", 64'h1122334444444444, image[63:0]);
    issue(mk(OPC_RIGHT, 64'h218, 16'h5, 64'h55667788, 1'b1), '0, 1'b1);
    issue(mk(OPC_RIGHT, 64'h1000, 16'hFFFD, 64'h1, 1'b0), '0, 1'b1);
    chk("pair word", 64'hA5A555667788A5A5, image[255:192]);
    issue(mk(6'h2B, 64'h40, 16'h1, 64'h1, 1'b0), '0, 1'b1);
    issue(mk(OPC_LEFT, 64'h40, 16'h1, 64'h1, 1'b0), '0, 1'b0);
    for (int e = 0; e < 5; e++) begin
      issue(mk(OPC_LEFT, 64'h7, 16'h0, 64'h1, 1'b0), uwsl_exc_t'(5'h1 << e), 1'b1);
    end
    repeat (300) begin
      opc = ($urandom_range(0, 5) == 5) ? 6'h2B : ($urandom_range(0, 1) ? OPC_LEFT : OPC_RIGHT);
      issue(mk(opc, {$urandom, $urandom}, 16'($urandom), {$urandom, $urandom}, 1'($urandom)),
        ($urandom_range(0, 9) == 0) ? uwsl_exc_t'(5'($urandom)) : '0, 1'b1);
    end
    issue(mk(6'h0, 64'h0, 16'h0, 64'h0, 1'b0), '0, 1'b0);
    complete_run();
  end
  initial begin
    #80000;
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
